// ===== pkg/sgoc_pkg.sv
// Shared constants and types for the system GPIO, observation and clock control registers
package sgoc_pkg;
  localparam int GPIO_W = 23;
  localparam int OBS_W = 18;
  localparam int NUM_OBS = 5;
  localparam logic [5:0] GPIO_MAX_PIN = 6'h16;
  localparam int REF_CLK_MHZ = 40;
  localparam int BUS_CLK_MHZ = 250;

  // Register byte offsets
  localparam logic [7:0] OFS_GPIO_IN = 8'h88;
  localparam logic [7:0] OFS_GPIO_OUT = 8'h90;
  localparam logic [7:0] OFS_GPIO_DIR = 8'h98;
  localparam logic [7:0] OFS_GPIO_INT_SEL = 8'hA0;
  localparam logic [7:0] OFS_PCI_CLK_DIV = 8'hA4;
  localparam logic [7:0] OFS_SCRATCH0 = 8'hA8;
  localparam logic [7:0] OFS_SCRATCH1 = 8'hAC;
  localparam logic [7:0] OFS_OBS_CTL = 8'hB0;
  localparam logic [7:0] OFS_GEN_CLK = 8'hB4;
  localparam logic [7:0] OFS_INT_MASK = 8'hB8;

  // Writable-bit masks, reserved bits read zero
  localparam logic [31:0] MASK_GPIO = 32'h007F_FFFF;
  localparam logic [31:0] MASK_INT_SEL = 32'h0000_FFFF;
  localparam logic [31:0] MASK_PCI_CLK = 32'h0000_FFFF;
  localparam logic [31:0] MASK_OBS = 32'h000F_FF3F;
  localparam logic [31:0] MASK_GEN_CLK = 32'h0000_0003;
  localparam logic [31:0] MASK_INT_MASK = 32'h0000_003F;

  // Cold reset values
  localparam logic [31:0] RST_GPIO_OUT = 32'h0000_0000;
  localparam logic [31:0] RST_GPIO_DIR = 32'h0000_0000;
  localparam logic [31:0] RST_INT_SEL = 32'h0000_0000;
  localparam logic [31:0] RST_PCI_CLK = 32'h0000_0000;
  localparam logic [31:0] RST_OBS = 32'h0000_0000;
  localparam logic [31:0] RST_GEN_CLK = 32'h0000_0001;
  localparam logic [31:0] RST_INT_MASK = 32'h0000_003F;

  // Field positions
  localparam int INT_SEL0_LSB = 0;
  localparam int INT_MODE0_LSB = 6;
  localparam int INT_SEL1_LSB = 8;
  localparam int INT_MODE1_LSB = 14;
  localparam int OBS_EN_BIT = 0;
  localparam int OBS_SRC_LSB = 1;
  localparam int OBS_DIR_BIT = 4;
  localparam int OBS_RADIO_BIT = 5;
  localparam int OBS_SEC_EN_BIT = 8;
  localparam int OBS_SEC_SRC_LSB = 9;
  localparam int OBS_CLKOBS_BIT = 12;
  localparam int OBS_PIN3_LSB = 13;
  localparam int OBS_LED0_BIT = 15;
  localparam int OBS_LED1_BIT = 16;
  localparam int OBS_TRIG_BIT = 17;
  localparam int OBS_COEX_BIT = 18;
  localparam int OBS_CARDBUS_BIT = 19;
  localparam int CLK_BYPASS_BIT = 0;
  localparam int CLK_PROC_SEL_BIT = 1;

  typedef enum logic [1:0] {
    SGOC_TEST_NEVER = 2'b00,
    SGOC_TEST_LOW = 2'b01,
    SGOC_TEST_HIGH = 2'b10,
    SGOC_TEST_CHANGE = 2'b11
  } sgoc_test_t;

  typedef enum logic [1:0] {
    SGOC_PIN3_GPIO = 2'b00,
    SGOC_PIN3_CHAN_CLEAR = 2'b01,
    SGOC_PIN3_CLKC = 2'b10
  } sgoc_pin3_t;

  typedef enum logic [1:0] {
    SGOC_FSEL_CLKM0 = 2'b00,
    SGOC_FSEL_CLKM1 = 2'b01,
    SGOC_FSEL_CLKC = 2'b10,
    SGOC_FSEL_REF = 2'b11
  } sgoc_fsel_t;

  // Observation sources: digital subsystem, converter in, converter out, wireless MAC, wired MAC
  typedef struct packed {
    logic [OBS_W-1:0] wired_mac;
    logic [OBS_W-1:0] wireless_mac;
    logic [OBS_W-1:0] conv_out;
    logic [OBS_W-1:0] conv_in;
    logic [OBS_W-1:0] digital_subsystem;
  } sgoc_obs_t;

  typedef struct packed {
    logic [GPIO_W-1:0] out;
    logic [GPIO_W-1:0] oe_n;
  } sgoc_pins_t;
endpackage

// ===== verilog/sgoc_regs.sv
// System GPIO, observation pin sharing and clock control register set
`timescale 1ns/1ps
`default_nettype none
module sgoc_regs (
  input wire logic CLOCK_I,
  input wire logic RESET_I,
  input wire logic WARM_RESET_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic REG_WE_I,
  input wire logic REG_RE_I,
  output logic [31:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  input wire logic [sgoc_pkg::GPIO_W-1:0] GPIO_IN_I,
  output logic [sgoc_pkg::GPIO_W-1:0] GPIO_OUT_O,
  output logic [sgoc_pkg::GPIO_W-1:0] GPIO_OE_N_O,
  output logic GPIO_INT_O,
  input wire sgoc_pkg::sgoc_obs_t OBS_SRC_I,
  output logic [sgoc_pkg::OBS_W-1:0] OBS_DATA_O,
  output logic OBS_EN_O,
  output logic OBS_IS_INPUT_O,
  output logic RADIO_MODE_O,
  input wire logic [3:0] RADIO_OUT_I,
  input wire logic [3:0] RADIO_OE_N_I,
  input wire logic CLKOBS_I,
  input wire logic CHAN_CLEAR_I,
  input wire logic LED0_I,
  input wire logic LED1_I,
  input wire logic TEST_TRIG_I,
  output logic COEX_ACTIVE_O,
  output logic CARDBUS_MODE_O,
  input wire logic PLL_CLKM_I,
  input wire logic PLL_CLKC_I,
  input wire logic INT_REF_CLK_I,
  input wire logic PROC_REF_CLK_I,
  input wire logic [1:0] FINAL_SEL_I,
  output logic PLL_BYPASS_O,
  output logic PROC_REF_SEL_O,
  output logic PLL_REF_O,
  output logic FINAL_SRC_O,
  output logic [15:0] PCI_CLK_CTL_O,
  output logic [5:0] CLIENT_INT_MASK_O
);
  import sgoc_pkg::*;

  logic [31:0] gpio_out_q;
  logic [31:0] gpio_dir_q;
  logic [31:0] int_sel_q;
  logic [31:0] pci_clk_q;
  logic [31:0] scratch0_q;
  logic [31:0] scratch1_q;
  logic [31:0] obs_q;
  logic [31:0] gen_clk_q;
  logic [31:0] int_mask_q;
  logic [GPIO_W-1:0] in_q;
  logic [GPIO_W-1:0] in_prev_q;
  logic int_d;
  logic [31:0] rdata_d;
  sgoc_pins_t pins_d;
  logic [OBS_W-1:0] sec_obs;
  logic ref_mux;

  // Masked write; reserved bits stay zero
  function automatic logic [31:0] wr_val(input logic [31:0] data, input logic [31:0] mask);
    wr_val = data & mask;
  endfunction

  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = REG_WE_I && (REG_ADDR_I == ofs);
  endfunction

  // Pin test: selectors beyond the last pin never fire
  function automatic logic pin_test(input logic [5:0] sel, input logic [1:0] mode,
                                    input logic [GPIO_W-1:0] cur, input logic [GPIO_W-1:0] prev);
    pin_test = 1'b0;
    if (sel <= GPIO_MAX_PIN) begin
      case (mode)
        SGOC_TEST_LOW: pin_test = !cur[sel[4:0]];
        SGOC_TEST_HIGH: pin_test = cur[sel[4:0]];
        SGOC_TEST_CHANGE: pin_test = cur[sel[4:0]] ^ prev[sel[4:0]];
        default: pin_test = 1'b0;
      endcase
    end
  endfunction

  // Five-way observation select; reserved codes give zero
  function automatic logic [OBS_W-1:0] obs_pick(input logic [2:0] src, input sgoc_obs_t b);
    case (src)
      3'h0: obs_pick = b.digital_subsystem;
      3'h1: obs_pick = b.conv_in;
      3'h2: obs_pick = b.conv_out;
      3'h3: obs_pick = b.wireless_mac;
      3'h4: obs_pick = b.wired_mac;
      default: obs_pick = '0;
    endcase
  endfunction

  // Control registers: cold reset only, warm reset leaves them alone
  // write or cold reset
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      gpio_out_q <= RST_GPIO_OUT;
      gpio_dir_q <= RST_GPIO_DIR;
      int_sel_q <= RST_INT_SEL;
      pci_clk_q <= RST_PCI_CLK;
      obs_q <= RST_OBS;
      gen_clk_q <= RST_GEN_CLK;
      int_mask_q <= RST_INT_MASK;
    end else begin
      if (wr_hit(OFS_GPIO_OUT)) begin
        gpio_out_q <= wr_val(REG_WDATA_I, MASK_GPIO);
      end
      if (wr_hit(OFS_GPIO_DIR)) begin
        gpio_dir_q <= wr_val(REG_WDATA_I, MASK_GPIO);
      end
      if (wr_hit(OFS_GPIO_INT_SEL)) begin
        int_sel_q <= wr_val(REG_WDATA_I, MASK_INT_SEL);
      end
      if (wr_hit(OFS_PCI_CLK_DIV)) begin
        pci_clk_q <= wr_val(REG_WDATA_I, MASK_PCI_CLK);
      end
      if (wr_hit(OFS_OBS_CTL)) begin
        obs_q <= wr_val(REG_WDATA_I, MASK_OBS);
      end
      if (wr_hit(OFS_GEN_CLK)) begin
        gen_clk_q <= wr_val(REG_WDATA_I, MASK_GEN_CLK);
      end
      if (wr_hit(OFS_INT_MASK)) begin
        int_mask_q <= wr_val(REG_WDATA_I, MASK_INT_MASK);
      end
    end
  end

  // Scratch has no reset term on purpose, so it survives every reset
  // scratch retention
  always_ff @(posedge CLOCK_I) begin
    if (wr_hit(OFS_SCRATCH0)) begin
      scratch0_q <= REG_WDATA_I;
    end
    if (wr_hit(OFS_SCRATCH1)) begin
      scratch1_q <= REG_WDATA_I;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      in_q <= '0;
      in_prev_q <= '0;
    end else begin
      in_q <= GPIO_IN_I;
      in_prev_q <= in_q;
    end
  end

  assign int_d = pin_test(int_sel_q[INT_SEL0_LSB +: 6], int_sel_q[INT_MODE0_LSB +: 2], in_q, in_prev_q)
              || pin_test(int_sel_q[INT_SEL1_LSB +: 6], int_sel_q[INT_MODE1_LSB +: 2], in_q, in_prev_q);

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      GPIO_INT_O <= 1'b0;
    end else begin
      GPIO_INT_O <= int_d;
    end
  end

  // Read decode; unmapped offsets read zero
  always_comb begin
    if (REG_ADDR_I == OFS_GPIO_IN) begin
      rdata_d = {9'h000, in_q};
    end else if (REG_ADDR_I == OFS_GPIO_OUT) begin
      rdata_d = gpio_out_q;
    end else if (REG_ADDR_I == OFS_GPIO_DIR) begin
      rdata_d = gpio_dir_q;
    end else if (REG_ADDR_I == OFS_GPIO_INT_SEL) begin
      rdata_d = int_sel_q;
    end else if (REG_ADDR_I == OFS_PCI_CLK_DIV) begin
      rdata_d = pci_clk_q;
    end else if (REG_ADDR_I == OFS_SCRATCH0) begin
      rdata_d = scratch0_q;
    end else if (REG_ADDR_I == OFS_SCRATCH1) begin
      rdata_d = scratch1_q;
    end else if (REG_ADDR_I == OFS_OBS_CTL) begin
      rdata_d = obs_q;
    end else if (REG_ADDR_I == OFS_GEN_CLK) begin
      rdata_d = gen_clk_q;
    end else if (REG_ADDR_I == OFS_INT_MASK) begin
      rdata_d = int_mask_q;
    end else begin
      rdata_d = 32'h0000_0000;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      REG_RDATA_O <= 32'h0000_0000;
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RVALID_O <= REG_RE_I;
      if (REG_RE_I) begin
        REG_RDATA_O <= rdata_d;
      end
    end
  end

  // Secondary bus bits 0..14 land on pins 8..22, then pins 1, 2, 6
  // secondary source
  assign sec_obs = obs_pick(obs_q[OBS_SEC_SRC_LSB +: 3], OBS_SRC_I);

  // Pin sharing, lowest priority first so later lines win
  always_comb begin
    pins_d.out = gpio_out_q[GPIO_W-1:0];
    pins_d.oe_n = ~gpio_dir_q[GPIO_W-1:0];
    if (obs_q[OBS_SEC_EN_BIT]) begin
      pins_d.out[22:8] = sec_obs[14:0];
      pins_d.out[1] = sec_obs[15];
      pins_d.out[2] = sec_obs[16];
      pins_d.out[6] = sec_obs[17];
      pins_d.oe_n[22:8] = '0;
      pins_d.oe_n[1] = 1'b0;
      pins_d.oe_n[2] = 1'b0;
      pins_d.oe_n[6] = 1'b0;
    end
    if (obs_q[OBS_LED0_BIT]) begin
      pins_d.out[1] = LED0_I;
      pins_d.oe_n[1] = 1'b0;
    end
    if (obs_q[OBS_LED1_BIT]) begin
      pins_d.out[2] = LED1_I;
      pins_d.oe_n[2] = 1'b0;
    end
    if (obs_q[OBS_TRIG_BIT]) begin
      pins_d.out[6] = TEST_TRIG_I;
      pins_d.oe_n[6] = 1'b0;
    end
    if (obs_q[OBS_CLKOBS_BIT]) begin
      pins_d.out[0] = CLKOBS_I;
      pins_d.oe_n[0] = 1'b0;
    end
    case (obs_q[OBS_PIN3_LSB +: 2])
      SGOC_PIN3_CHAN_CLEAR: begin
        pins_d.out[3] = CHAN_CLEAR_I;
        pins_d.oe_n[3] = 1'b0;
      end
      SGOC_PIN3_CLKC: begin
        pins_d.out[3] = PLL_CLKC_I;
        pins_d.oe_n[3] = 1'b0;
      end
      default: begin
      end
    endcase
    if (obs_q[OBS_COEX_BIT]) begin
      pins_d.oe_n[7] = 1'b1;
    end
    if (obs_q[OBS_RADIO_BIT]) begin
      pins_d.out[3:0] = RADIO_OUT_I;
      pins_d.oe_n[3:0] = RADIO_OE_N_I;
    end
  end

  // Pin outputs are registered to keep glitches off the pads
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      GPIO_OUT_O <= '0;
      GPIO_OE_N_O <= '1;
      COEX_ACTIVE_O <= 1'b0;
    end else begin
      GPIO_OUT_O <= pins_d.out;
      GPIO_OE_N_O <= pins_d.oe_n;
      COEX_ACTIVE_O <= obs_q[OBS_COEX_BIT] & in_q[7];
    end
  end

  // Primary observation bus and mode levels
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      OBS_DATA_O <= '0;
      OBS_EN_O <= 1'b0;
      OBS_IS_INPUT_O <= 1'b0;
      RADIO_MODE_O <= 1'b0;
      CARDBUS_MODE_O <= 1'b0;
    end else begin
      OBS_DATA_O <= obs_pick(obs_q[OBS_SRC_LSB +: 3], OBS_SRC_I);
      OBS_EN_O <= obs_q[OBS_EN_BIT];
      OBS_IS_INPUT_O <= obs_q[OBS_DIR_BIT];
      RADIO_MODE_O <= obs_q[OBS_RADIO_BIT];
      CARDBUS_MODE_O <= obs_q[OBS_CARDBUS_BIT];
    end
  end

  // Clock controls are plain levels; the clocks themselves are outside
  assign PLL_BYPASS_O = gen_clk_q[CLK_BYPASS_BIT];
  assign PROC_REF_SEL_O = gen_clk_q[CLK_PROC_SEL_BIT];
  assign PCI_CLK_CTL_O = pci_clk_q[15:0];
  assign CLIENT_INT_MASK_O = int_mask_q[5:0];

  assign PLL_REF_O = INT_REF_CLK_I;
  assign ref_mux = gen_clk_q[CLK_PROC_SEL_BIT] ? PROC_REF_CLK_I : INT_REF_CLK_I;

  always_comb begin
    case (FINAL_SEL_I)
      SGOC_FSEL_CLKC: FINAL_SRC_O = PLL_CLKC_I;
      SGOC_FSEL_REF: FINAL_SRC_O = ref_mux;
      default: FINAL_SRC_O = PLL_CLKM_I;
    endcase
  end

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);
  AST_DIR_DRIVE: assert property (
    !obs_q[OBS_SEC_EN_BIT] |=> GPIO_OE_N_O[22:8] == ~$past(gpio_dir_q[22:8]))
    else $error("direction bits not reflected on pin enables");
  AST_SEL_RANGE: assert property (
    (int_sel_q[5:0] > GPIO_MAX_PIN && int_sel_q[15:14] == 2'b00) |=> !GPIO_INT_O)
    else $error("out of range selector raised interrupt");
  AST_SEL1_HIGH: assert property (
    (int_sel_q[7:6] == 2'b00 && int_sel_q[15:14] == 2'b10 && int_sel_q[13:8] <= GPIO_MAX_PIN
      && in_q[int_sel_q[12:8]]) |=> GPIO_INT_O)
    else $error("second selector high test missed");
  AST_LOW_TEST: assert property (
    (int_sel_q[7:6] == 2'b01 && int_sel_q[5:0] <= GPIO_MAX_PIN && !in_q[int_sel_q[4:0]]) |=> GPIO_INT_O)
    else $error("low test missed");
  AST_NEVER: assert property (
    (int_sel_q[7:6] == 2'b00 && int_sel_q[15:14] == 2'b00) |=> !GPIO_INT_O)
    else $error("interrupt without any test enabled");
  AST_SCRATCH_KEEP: assert property (
    (!REG_WE_I || (REG_ADDR_I != OFS_SCRATCH0)) |=> scratch0_q === $past(scratch0_q))
    else $error("scratch changed without write");
  AST_LED_PRIO: assert property (
    (obs_q[OBS_LED0_BIT] && !obs_q[OBS_RADIO_BIT]) |=> GPIO_OUT_O[1] == $past(LED0_I) && !GPIO_OE_N_O[1])
    else $error("LED0 lost pin 1");
  AST_COEX_IN: assert property (
    (obs_q[OBS_COEX_BIT]) |=> GPIO_OE_N_O[7])
    else $error("coexistence pin driven");
  AST_READ_LAT: assert property (
    (REG_RE_I && REG_ADDR_I == OFS_GEN_CLK) |=> REG_RVALID_O && REG_RDATA_O[31:2] == '0)
    else $error("reserved bits read nonzero");
  AST_REF_SEL: assert property (
    (FINAL_SEL_I == 2'b11 && gen_clk_q[CLK_PROC_SEL_BIT]) |-> FINAL_SRC_O == PROC_REF_CLK_I)
    else $error("raw reference not from external pin");
  AST_WARM_KEEP: assert property (
    (WARM_RESET_I && !REG_WE_I) |=> obs_q == $past(obs_q) && gen_clk_q == $past(gen_clk_q))
    else $error("warm reset changed control registers");
  COV_CHANGE_INT: cover property (int_sel_q[7:6] == 2'b11 ##1 GPIO_INT_O);
  COV_SEC_BUS: cover property (obs_q[OBS_SEC_EN_BIT] && obs_q[OBS_LED1_BIT]);
  COV_RADIO: cover property (RADIO_MODE_O ##1 !RADIO_MODE_O);
  COV_SCRATCH_RD: cover property (REG_RE_I && REG_ADDR_I == OFS_SCRATCH1 ##1 REG_RVALID_O);
endmodule
`default_nettype wire

// ===== tb/sgoc_pin_model.sv
// Pad model: board levels on the GPIO pins, overridden where the device drives
`timescale 1ns/1ps
`default_nettype none
module sgoc_pin_model (
  input wire logic [sgoc_pkg::GPIO_W-1:0] pad_out_i,
  input wire logic [sgoc_pkg::GPIO_W-1:0] pad_oe_n_i,
  input wire logic [sgoc_pkg::GPIO_W-1:0] ext_level_i,
  output logic [sgoc_pkg::GPIO_W-1:0] pad_level_o
);
  import sgoc_pkg::*;
  // A driven pin reads back its own drive, so input sampling sees loopback
  always_comb begin
    pad_level_o = (pad_out_i & ~pad_oe_n_i) | (ext_level_i & pad_oe_n_i);
  end
endmodule
`default_nettype wire

// ===== tb/test_system_gpio_obs_clock_control.sv
// Self-checking bench for the GPIO, observation and clock control registers
`timescale 1ns/1ps
`default_nettype none
module test_system_gpio_obs_clock_control;
  import sgoc_pkg::*;
  logic clock, reset, warm, we, re, rvalid, gint, obs_en, obs_in, radio, coex, cardbus;
  logic clkobs, chclr, led0, led1, trig, clkm, clkc, iref, pref, bypass, psel, pllref, fsrc;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, t, o, d;
  logic [GPIO_W-1:0] gin, gout, goe_n, ext;
  logic [3:0] rf_out, rf_oe_n;
  logic [1:0] fsel;
  logic [15:0] pci;
  logic [5:0] mask;
  logic [17:0] obs_data;
  logic [95:0] r96;
  sgoc_obs_t obs;
  logic [31:0] expq[$];
  int fail_count, n_compared, cnt;
  integer seed;
  logic [7:0] ta[6] = '{OFS_GPIO_DIR, OFS_GPIO_INT_SEL, OFS_PCI_CLK_DIV, OFS_OBS_CTL, OFS_GEN_CLK, OFS_INT_MASK};
  logic [31:0] tm[6] = '{MASK_GPIO, MASK_INT_SEL, MASK_PCI_CLK, MASK_OBS, MASK_GEN_CLK, MASK_INT_MASK};

  always #2 clock = ~clock;

  sgoc_regs u_sgoc_regs (
    .CLOCK_I(clock), .RESET_I(reset), .WARM_RESET_I(warm), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WE_I(we), .REG_RE_I(re), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .GPIO_IN_I(gin),
    .GPIO_OUT_O(gout), .GPIO_OE_N_O(goe_n), .GPIO_INT_O(gint), .OBS_SRC_I(obs), .OBS_DATA_O(obs_data),
    .OBS_EN_O(obs_en), .OBS_IS_INPUT_O(obs_in), .RADIO_MODE_O(radio), .RADIO_OUT_I(rf_out),
    .RADIO_OE_N_I(rf_oe_n), .CLKOBS_I(clkobs), .CHAN_CLEAR_I(chclr), .LED0_I(led0), .LED1_I(led1),
    .TEST_TRIG_I(trig), .COEX_ACTIVE_O(coex), .CARDBUS_MODE_O(cardbus), .PLL_CLKM_I(clkm),
    .PLL_CLKC_I(clkc), .INT_REF_CLK_I(iref), .PROC_REF_CLK_I(pref), .FINAL_SEL_I(fsel),
    .PLL_BYPASS_O(bypass), .PROC_REF_SEL_O(psel), .PLL_REF_O(pllref), .FINAL_SRC_O(fsrc),
    .PCI_CLK_CTL_O(pci), .CLIENT_INT_MASK_O(mask)
  );

  sgoc_pin_model u_sgoc_pin_model (.pad_out_i(gout), .pad_oe_n_i(goe_n), .ext_level_i(ext), .pad_level_o(gin));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    #1;
    addr = a;
    wdata = v;
    we = 1'b1;
    @(posedge clock);
    #1;
    we = 1'b0;
  endtask

  // Expected data is queued before the strobe; the monitor pairs it with the answer
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    @(posedge clock);
    #1;
    addr = a;
    re = 1'b1;
    @(posedge clock);
    #1;
    re = 1'b0;
  endtask

  task automatic settle;
    repeat (4) @(posedge clock);
    #1;
  endtask

  task automatic cold_reset;
    @(posedge clock);
    #1;
    reset = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    reset = 1'b0;
  endtask

  always @(negedge clock) begin
    if (rvalid === 1'b1) begin
      t = (expq.size() > 0) ? expq.pop_front() : ~rdata;
      check(rdata, t);
    end
  end

  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    finish_test;
  end

  initial begin
    seed = 32'hbb8f;
    clock = 1'b0;
    reset = 1'b1;
    warm = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    we = 1'b0;
    re = 1'b0;
    ext = '0;
    r96 = {$random(seed), $random(seed), $random(seed)};
    obs = r96[89:0];
    rf_out = 4'hA;
    rf_oe_n = 4'h5;
    // Reference levels differ so a wrong clock choice shows up
    {clkobs, chclr, led0, led1, trig, clkm, clkc, iref, pref} = 9'h1D5;
    fsel = 2'h3;
    n_compared = 0;
    fail_count = 0;
    repeat (3) @(posedge clock);
    #1;
    reset = 1'b0;
    rd(OFS_GPIO_DIR, RST_GPIO_DIR);
    rd(OFS_GPIO_INT_SEL, RST_INT_SEL);
    rd(OFS_OBS_CTL, RST_OBS);
    rd(OFS_GEN_CLK, RST_GEN_CLK);
    rd(OFS_INT_MASK, RST_INT_MASK);
    rd(8'h00, 32'h0000_0000);
    check({9'h0, goe_n}, MASK_GPIO);
    $display("test reset_values done");
    for (int i = 0; i < 6; i++) begin
      wr(ta[i], 32'hFFFF_FFFF);
      rd(ta[i], tm[i]);
    end
    $display("test reserved_bits done");
    warm = 1'b1;
    settle();
    warm = 1'b0;
    rd(OFS_OBS_CTL, MASK_OBS);
    rd(OFS_GEN_CLK, MASK_GEN_CLK);
    $display("test warm_reset done");
    o = $random(seed);
    d = $random(seed);
    wr(OFS_SCRATCH0, o);
    wr(OFS_SCRATCH1, d);
    warm = 1'b1;
    cold_reset();
    warm = 1'b0;
    rd(OFS_SCRATCH0, o);
    rd(OFS_SCRATCH1, d);
    rd(OFS_OBS_CTL, RST_OBS);
    $display("test scratch_reset done");
    ext = GPIO_W'($random(seed));
    wr(OFS_GPIO_OUT, o);
    wr(OFS_GPIO_DIR, d);
    wr(OFS_GPIO_IN, 32'hFFFF_FFFF);
    settle();
    check({9'h0, goe_n}, ~d & MASK_GPIO);
    check({9'h0, gout} & d & MASK_GPIO, o & d & MASK_GPIO);
    rd(OFS_GPIO_IN, ((o & d) | ({9'h0, ext} & ~d)) & MASK_GPIO);
    wr(OFS_GPIO_DIR, 32'h0000_0000);
    $display("test gpio_pins done");
    for (int m = 0; m < 4; m++) begin
      for (int lv = 0; lv < 2; lv++) begin
        ext[5] = lv[0];
        wr(OFS_GPIO_INT_SEL, 32'(m * 64 + 5));
        settle();
        check({31'h0, gint}, {31'h0, (m == 1 && lv == 0) || (m == 2 && lv == 1)});
      end
    end
    ext[5] = 1'b0;
    cnt = 0;
    repeat (6) begin
      @(posedge clock);
      #1;
      cnt += (gint === 1'b1);
    end
    check(cnt, 1);
    // Selector 0 points past the last pin with a low test, selector 1 tests pin 9 high
    ext[9] = 1'b0;
    wr(OFS_GPIO_INT_SEL, 32'h0000_0057);
    settle();
    check({31'h0, gint}, 32'h0000_0000);
    wr(OFS_GPIO_INT_SEL, 32'h0000_8957);
    settle();
    check({31'h0, gint}, 32'h0000_0000);
    ext[9] = 1'b1;
    settle();
    check({31'h0, gint}, 32'h0000_0001);
    wr(OFS_GPIO_INT_SEL, 32'h0000_8900);
    settle();
    check({31'h0, gint}, 32'h0000_0001);
    $display("test gpio_interrupt done");
    for (int s = 0; s < 8; s++) begin
      wr(OFS_OBS_CTL, 32'(1 + s * 2));
      settle();
      check({14'h0, obs_data}, (s < NUM_OBS) ? {14'h0, r96[s*18 +: 18]} : 32'h0000_0000);
      check({31'h0, obs_en}, 32'h0000_0001);
    end
    ext[7] = 1'b1;
    wr(OFS_OBS_CTL, 32'h000C_0031);
    settle();
    check({28'h0, cardbus, coex, radio, obs_in}, 32'h0000_000F);
    check({24'h0, goe_n[3:0], gout[3:0]}, {24'h0, rf_oe_n, rf_out});
    wr(OFS_GPIO_OUT, 32'h0000_0000);
    wr(OFS_OBS_CTL, 32'h0003_B100);
    settle();
    check({26'h0, obs_en, gout[6], gout[3:0]}, {26'h0, 1'b0, trig, chclr, led1, led0, clkobs});
    check({17'h0, gout[22:8]}, {17'h0, r96[14:0]});
    wr(OFS_OBS_CTL, 32'h0000_4000);
    settle();
    check({31'h0, gout[3]}, {31'h0, clkc});
    $display("test pin_sharing done");
    wr(OFS_GEN_CLK, 32'h0000_0002);
    settle();
    check({29'h0, bypass, psel, fsrc}, {29'h0, 1'b0, 1'b1, pref});
    wr(OFS_GEN_CLK, 32'h0000_0000);
    settle();
    check({29'h0, psel, fsrc, pllref}, {29'h0, 1'b0, iref, iref});
    fsel = 2'h2;
    #1;
    check({31'h0, fsrc}, {31'h0, clkc});
    @(posedge clock);
    #1;
    fsel = 2'h0;
    #1;
    check({31'h0, fsrc}, {31'h0, clkm});
    wr(OFS_PCI_CLK_DIV, o);
    settle();
    check({16'h0, pci}, o & MASK_PCI_CLK);
    $display("test clock_control done");
    wr(OFS_INT_MASK, 32'h0000_0015);
    settle();
    check({26'h0, mask}, 32'h0000_0015);
    rd(OFS_INT_MASK, 32'h0000_0015);
    $display("test interrupt_mask done");
    cnt = 0;
    while (expq.size() > 0 && cnt < 50) begin
      @(posedge clock);
      cnt++;
    end
    if (expq.size() > 0) begin
      fail_count++;
    end
    finish_test();
  end
endmodule
`default_nettype wire
